// ### card_supervisor_power_ctrl.v
`timescale 1ns/10ps
`default_nettype none
`include "card_supervisor_defs.vh"

module card_supervisor_power_ctrl (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // register port from the controller
  input wire [3:0] i_reg_addr,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [7:0] i_reg_wdata,
  output reg [7:0] o_reg_rdata,
  // controller side
  input wire i_power_down_bit,
  input wire i_ext_irq_enable,
  output reg o_irq_out_n,
  output reg o_ctrl_reset,
  output reg o_wake_resume,
  // pins and analog detectors
  input wire i_card_detect_pin,
  input wire i_supply_alarm,
  input wire i_shutdown_in_n,
  input wire i_ext_reset_pin,
  input wire i_oc_vcc,
  input wire i_oc_rst,
  input wire i_overtemp,
  input wire i_rx,
  input wire i_ext_irq_in_n,
  input wire i_converter_supply_pin_high,
  // converter control
  output wire o_conv_en,
  output reg o_conv_clk,
  output reg [1:0] o_conv_mode,
  // card contacts
  output wire o_card_vcc_en,
  output wire o_card_io_en,
  output wire o_card_clk_en,
  output reg o_card_rst,
  output reg o_clk_stop,
  output reg o_clk_stop_high,
  // power modes
  output reg o_power_down_mode,
  output reg o_sleep_mode,
  output reg o_bias_reduced
);

  localparam [`SYNC_W-1:0] SYNC_INIT = `SYNC_RST;
  localparam integer CONV_LAST = `CONV_HALF_CYC - 1;
  localparam integer WAKE_LAST = `WAKE_CYC - 1;

  // synchroniser stages
  reg [`SYNC_W-1:0] meta_q;
  reg [`SYNC_W-1:0] sync_q;
  wire [`SYNC_W-1:0] pins_in;

  // edge history
  reg card_detect_pin_prev_q;
  reg shutdown_flag_prev_q;
  reg rx_prev_q;
  reg xirq_prev_q;

  // internal power-on reset
  reg por_q;

  // software registers
  reg [7:0] run_q;
  reg [7:0] clkcfg_q;
  reg [7:0] baud_q;
  reg [7:0] ucfgb_q;
  reg [7:0] guard_q;
  reg [7:0] ucfga_q;
  reg [7:0] pwr_q;
  reg [7:0] toc_q;

  // hardware status flags
  reg supply_low_flag_q;
  reg shutdown_flag_f_q;
  reg oc_f_q;
  reg pchg_q;
  reg ot_f_q;

  // converter clock and wake timer
  reg [3:0] conv_cnt_q;
  reg wake_busy_q;
  reg [10:0] wake_cnt_q;

  // sequencer enables
  wire seq_rst_en;

  // synchronised pin views
  wire card_detect_pin;
  wire alarm;
  wire shutdown_in_n;
  wire xrst;
  wire ocv;
  wire ocr;
  wire otemp;
  wire rx;
  wire xirq_n;
  wire dc_high;

  // derived events
  wire card_detect_pin_tog;
  wire shutdown_flag_rise;
  wire rx_fall;
  wire xirq_fall;
  wire hs_rd;
  wire emerg;
  wire low_power;
  wire wake_ev;
  wire [7:0] hsr_val;
  wire [7:0] msr_val;

  assign pins_in = {i_converter_supply_pin_high, i_ext_irq_in_n, i_rx, i_overtemp,
                    i_oc_rst, i_oc_vcc, i_ext_reset_pin, i_shutdown_in_n,
                    i_supply_alarm, i_card_detect_pin};

  // two flops per pin, only the second stage is read
  genvar g;
  generate
    for (g = 0; g < `SYNC_W; g = g + 1) begin : g_sync
      always @(posedge i_core_clk) begin
        if (i_rst) begin
          meta_q[g] <= SYNC_INIT[g];
          sync_q[g] <= SYNC_INIT[g];
        end else begin
          meta_q[g] <= pins_in[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign card_detect_pin = sync_q[`S_CARD_DETECT_PIN];
  assign alarm = sync_q[`S_ALARM];
  assign shutdown_in_n = sync_q[`S_SHUTDOWN_IN_N];
  assign xrst = sync_q[`S_XRST];
  assign ocv = sync_q[`S_OCV];
  assign ocr = sync_q[`S_OCR];
  assign otemp = sync_q[`S_OT];
  assign rx = sync_q[`S_RX];
  assign xirq_n = sync_q[`S_XIRQ_N];
  assign dc_high = sync_q[`S_DCHI];

  // edge history on synchronised levels only
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      card_detect_pin_prev_q <= 1'b0;
      shutdown_flag_prev_q <= 1'b1;
      rx_prev_q <= 1'b1;
      xirq_prev_q <= 1'b1;
    end else begin
      card_detect_pin_prev_q <= card_detect_pin;
      shutdown_flag_prev_q <= shutdown_in_n;
      rx_prev_q <= rx;
      xirq_prev_q <= xirq_n;
    end
  end

  assign card_detect_pin_tog = card_detect_pin ^ card_detect_pin_prev_q;
  assign shutdown_flag_rise = shutdown_in_n & ~shutdown_flag_prev_q;
  assign rx_fall = rx_prev_q & ~rx;
  assign xirq_fall = xirq_prev_q & ~xirq_n;

  // alarm, reset pin and shut-down release all restart the chip
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      por_q <= 1'b1;
      o_ctrl_reset <= 1'b1;
    end else begin
      por_q <= alarm | xrst | shutdown_flag_rise;
      o_ctrl_reset <= alarm | xrst | shutdown_flag_rise;
    end
  end

  // any fault during a session tears the card down
  assign emerg = pwr_q[`B_START] & (~card_detect_pin | ocv | ocr | otemp | alarm);
  assign hs_rd = i_reg_rd & (i_reg_addr == `A_HSTAT);

  // software registers; the chip-level reset clears them all
  always @(posedge i_core_clk) begin
    if (por_q) begin
      run_q <= `R_ZERO;
      clkcfg_q <= `R_ZERO;
      baud_q <= `R_ZERO;
      ucfgb_q <= `R_ZERO;
      guard_q <= `R_ZERO;
      ucfga_q <= `R_ZERO;
      pwr_q <= `R_ZERO;
      toc_q <= `R_ZERO;
    end else begin
      if (i_reg_wr) begin
        case (i_reg_addr)
          `A_RUN: run_q <= i_reg_wdata & `M_RUN;
          `A_CLKCFG: clkcfg_q <= i_reg_wdata & `M_CLKCFG;
          `A_BAUD: baud_q <= i_reg_wdata;
          `A_UCFGB: ucfgb_q <= i_reg_wdata & `M_UCFGB;
          `A_GUARD: guard_q <= i_reg_wdata;
          `A_UCFGA: ucfga_q <= i_reg_wdata & `M_UCFGA;
          `A_PWR: begin
            pwr_q <= i_reg_wdata & `M_PWR;
            // a start request needs a card and a healthy supply
            pwr_q[`B_START] <= i_reg_wdata[`B_START] & card_detect_pin & ~alarm;
          end
          `A_TOC: toc_q <= i_reg_wdata;
          default: ;
        endcase
      end
      // uart held in reset: reload the cleared fields
      if (!run_q[`B_RUN]) begin
        toc_q <= `R_ZERO;
        ucfga_q <= ucfga_q & `M_UCFGA_RUN0;
      end
      if (emerg) begin
        pwr_q[`B_START] <= 1'b0;
      end
    end
  end

  // status flags: a live cause beats the clear-on-read
  always @(posedge i_core_clk) begin
    if (por_q) begin
      supply_low_flag_q <= 1'b1;
      shutdown_flag_f_q <= 1'b0;
      oc_f_q <= 1'b0;
      pchg_q <= 1'b0;
      ot_f_q <= 1'b0;
    end else begin
      if (hs_rd & ~alarm) supply_low_flag_q <= 1'b0;
      shutdown_flag_f_q <= ~shutdown_in_n | (shutdown_flag_f_q & ~hs_rd);
      oc_f_q <= ocv | ocr | (oc_f_q & ~hs_rd);
      pchg_q <= card_detect_pin_tog | (pchg_q & ~hs_rd);
      ot_f_q <= otemp | (ot_f_q & ~hs_rd);
    end
  end

  // interrupt low while in reset or any flag stands
  always @(posedge i_core_clk) begin
    if (por_q) begin
      o_irq_out_n <= 1'b0;
    end else begin
      o_irq_out_n <= ~(supply_low_flag_q | shutdown_flag_f_q | oc_f_q | pchg_q | ot_f_q);
    end
  end

  assign hsr_val = {shutdown_flag_f_q, 1'b0, oc_f_q, supply_low_flag_q, 1'b0, pchg_q, 1'b0, ot_f_q};
  // no receive fifo here, so the empty bit reads set
  assign msr_val = `MSR_FIXED | ({7'h00, card_detect_pin} << `B_CARD_DETECT_PIN);

  // read data is registered; offsets without a register read as zero
  always @(posedge i_core_clk) begin
    if (por_q) begin
      o_reg_rdata <= `R_ZERO;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `A_RUN: o_reg_rdata <= run_q;
        `A_CLKCFG: o_reg_rdata <= clkcfg_q;
        `A_BAUD: o_reg_rdata <= baud_q;
        `A_UCFGB: o_reg_rdata <= ucfgb_q;
        `A_GUARD: o_reg_rdata <= guard_q;
        `A_UCFGA: o_reg_rdata <= ucfga_q;
        `A_PWR: o_reg_rdata <= pwr_q;
        `A_TOC: o_reg_rdata <= toc_q;
        `A_FIFO_MIX: o_reg_rdata <= msr_val;
        `A_HSTAT: o_reg_rdata <= hsr_val;
        // receive data and uart status stay zero without a uart
        default: o_reg_rdata <= `R_ZERO;
      endcase
    end
  end

  // activation and deactivation sequencer
  card_seq u_seq (
    .i_core_clk (i_core_clk),
    .i_rst (i_rst),
    .i_start (pwr_q[`B_START]),
    .o_conv_en (o_conv_en),
    .o_vcc_en (o_card_vcc_en),
    .o_io_en (o_card_io_en),
    .o_clk_en (o_card_clk_en),
    .o_rst_en (seq_rst_en)
  );

  // card reset follows software value only while enabled
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_card_rst <= 1'b0;
    end else begin
      o_card_rst <= seq_rst_en & pwr_q[`B_RSTV];
    end
  end

  // converter mode from input level and chosen card supply
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_conv_mode <= `CM_FOLLOW;
    end else if (pwr_q[`B_1V8]) begin
      o_conv_mode <= `CM_FOLLOW;
    end else if (dc_high) begin
      o_conv_mode <= pwr_q[`B_3V] ? `CM_FOLLOW : `CM_DOUBLE;
    end else begin
      o_conv_mode <= pwr_q[`B_3V] ? `CM_DOUBLE : `CM_TRIPLE;
    end
  end

  // pump clock divided from core clock, stopped with converter
  always @(posedge i_core_clk) begin
    if (i_rst | ~o_conv_en) begin
      conv_cnt_q <= 4'h0;
      o_conv_clk <= 1'b0;
    end else if (conv_cnt_q == CONV_LAST[3:0]) begin
      conv_cnt_q <= 4'h0;
      o_conv_clk <= ~o_conv_clk;
    end else begin
      conv_cnt_q <= conv_cnt_q + 4'h1;
    end
  end

  // power modes: card state decides power-down versus sleep
  always @(posedge i_core_clk) begin
    if (por_q) begin
      o_power_down_mode <= 1'b0;
      o_sleep_mode <= 1'b0;
      o_bias_reduced <= 1'b0;
      o_clk_stop <= 1'b0;
      o_clk_stop_high <= 1'b0;
    end else begin
      o_power_down_mode <= i_power_down_bit & ~o_card_vcc_en;
      o_sleep_mode <= i_power_down_bit & o_card_vcc_en;
      o_bias_reduced <= i_power_down_bit;
      o_clk_stop <= (i_power_down_bit & o_card_vcc_en) | clkcfg_q[`B_CST];
      o_clk_stop_high <= clkcfg_q[`B_SHL];
    end
  end

  assign low_power = o_power_down_mode | o_sleep_mode;
  assign wake_ev = low_power & (card_detect_pin_tog | ocv | ocr | xrst
                   | (rx_fall & ucfgb_q[`B_RXWK])
                   | (xirq_fall & ucfgb_q[`B_IRQWK] & i_ext_irq_enable));

  // resume only after the oscillator restart wait
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      wake_busy_q <= 1'b0;
      wake_cnt_q <= 11'h000;
      o_wake_resume <= 1'b0;
    end else begin
      o_wake_resume <= 1'b0;
      if (!wake_busy_q) begin
        wake_cnt_q <= 11'h000;
        if (wake_ev) wake_busy_q <= 1'b1;
      end else if (wake_cnt_q == WAKE_LAST[10:0]) begin
        wake_busy_q <= 1'b0;
        o_wake_resume <= 1'b1;
      end else begin
        wake_cnt_q <= wake_cnt_q + 11'h001;
      end
    end
  end

endmodule

`default_nettype wire

// ### card_supervisor_defs.vh
// Contract
// - run bit low zeroes timeout config and data
// - contacts stay inactive during supply ramp
// - alarm pulse resets chip, forces deactivation
// - supply-low flag held until read without alarm
// - interrupt output low during power-on reset
// - shut-down exit or reset pin act as power-on
// - session start begins with converter start
// - converter mode chosen from input and card voltage
// - activation only with card present, no alarm
// - presence bit shown, toggle sets change flag
// - faults deactivate card, set status, interrupt
// - supply or reset overcurrent deactivates card
// - die overtemperature deactivates card
// - shut-down input low sets flag and interrupt
// - shut-down release performs full power-on reset
// - power-down: controller halted, card inactive, reduced
// - sleep: controller halted, card powered, clock stopped
// - wake on presence, overcurrent, reset pin
// - wake on enabled receive or external interrupt edges
// - wake waits 1536 cycles before resume
// - activation steps converter, supply, io, clock/reset
// - deactivation: reset, clock, io, supply, converter
// - emergency deactivation clears activate bit
`ifndef CARD_SUP_DEFS_VH
`define CARD_SUP_DEFS_VH

// register offsets
`define A_RUN 4'h0
`define A_CLKCFG 4'h1
`define A_BAUD 4'h2
`define A_UCFGB 4'h3
`define A_GUARD 4'h5
`define A_UCFGA 4'h6
`define A_PWR 4'h7
`define A_TOC 4'h8
`define A_FIFO_MIX 4'hc
`define A_DATA 4'hd
`define A_USTAT 4'he
`define A_HSTAT 4'hf

// field positions
`define B_RUN 3
`define B_START 0
`define B_3V 1
`define B_RSTV 2
`define B_1V8 3
`define B_RXWK 4
`define B_IRQWK 7
`define B_CST 4
`define B_SHL 5
`define B_CARD_DETECT_PIN 2
`define B_SHUTDOWN_FLAG 7
`define B_OC 5
`define B_SUPPLY_LOW_FLAG 4
`define B_PCHG 2
`define B_OT 0

// reset values and writable masks
`define R_ZERO 8'h00
`define MSR_FIXED 8'h40
`define M_RUN 8'h08
`define M_CLKCFG 8'h3f
`define M_UCFGB 8'hdf
`define M_UCFGA 8'h7f
`define M_PWR 8'h0f
`define M_UCFGA_RUN0 8'h73

// converter modes
`define CM_FOLLOW 2'h0
`define CM_DOUBLE 2'h1
`define CM_TRIPLE 2'h2

// timing
`define CLK_NS 20
`define CLK_HZ 50000000
`define T_STEP_NS 25000
`define HALF_CYC ((`T_STEP_NS / 2) / `CLK_NS)
`define DEACT_DLY_CYC ((`T_STEP_NS * 3 + 64 * `CLK_NS - 1) / (64 * `CLK_NS))
`define OSC_HZ 2500000
`define CONV_HALF_CYC (`CLK_HZ / (2 * `OSC_HZ))
`define WAKE_CYC 1536

// synchroniser bit map
`define SYNC_W 10
`define SYNC_RST 10'h184
`define S_CARD_DETECT_PIN 0
`define S_ALARM 1
`define S_SHUTDOWN_IN_N 2
`define S_XRST 3
`define S_OCV 4
`define S_OCR 5
`define S_OT 6
`define S_RX 7
`define S_XIRQ_N 8
`define S_DCHI 9

`endif

// ### card_seq.v
`timescale 1ns/10ps
`default_nettype none
`include "card_supervisor_defs.vh"

module card_seq (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // session request level
  input wire i_start,
  // contact and converter enables
  output reg o_conv_en,
  output reg o_vcc_en,
  output reg o_io_en,
  output reg o_clk_en,
  output reg o_rst_en
);

  localparam ST_IDLE = 2'h0;
  localparam ST_ACT = 2'h1;
  localparam ST_ON = 2'h2;
  localparam ST_DEACT = 2'h3;
  localparam integer HALF_LAST = `HALF_CYC - 1;
  localparam integer DLY_LAST = `DEACT_DLY_CYC - 1;

  reg [1:0] state_q;
  reg [9:0] hc_q;
  reg [2:0] step_q;
  wire tick;

  // one tick per half sequencer step
  assign tick = (hc_q == HALF_LAST[9:0]);

  // step counter; enables change on a tick, except converter start and the reset drop after the deactivation delay
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      hc_q <= 10'h000;
      step_q <= 3'h0;
      o_conv_en <= 1'b0;
      o_vcc_en <= 1'b0;
      o_io_en <= 1'b0;
      o_clk_en <= 1'b0;
      o_rst_en <= 1'b0;
    end else begin
      hc_q <= tick ? 10'h000 : hc_q + 10'h001;
      case (state_q)
        ST_IDLE: begin
          hc_q <= 10'h000;
          step_q <= 3'h0;
          if (i_start) begin
            o_conv_en <= 1'b1;
            state_q <= ST_ACT;
          end
        end
        ST_ACT: begin
          if (!i_start) begin
            state_q <= ST_DEACT;
            hc_q <= 10'h000;
            step_q <= 3'h0;
          end else if (tick) begin
            step_q <= step_q + 3'h1;
            if (step_q == 3'h2) o_vcc_en <= 1'b1;
            if (step_q == 3'h6) o_io_en <= 1'b1;
            if (step_q == 3'h7) begin
              o_clk_en <= 1'b1;
              o_rst_en <= 1'b1;
              state_q <= ST_ON;
            end
          end
        end
        ST_ON: begin
          hc_q <= 10'h000;
          step_q <= 3'h0;
          if (!i_start) state_q <= ST_DEACT;
        end
        ST_DEACT: begin
          // a new start waits until the card is fully down
          if (step_q == 3'h0) begin
            if (hc_q == DLY_LAST[9:0]) begin
              o_rst_en <= 1'b0;
              step_q <= 3'h1;
              hc_q <= 10'h000;
            end
          end else if (tick) begin
            step_q <= step_q + 3'h1;
            if (step_q == 3'h1) o_clk_en <= 1'b0;
            if (step_q == 3'h2) o_io_en <= 1'b0;
            if (step_q == 3'h3) o_vcc_en <= 1'b0;
            if (step_q == 3'h7) begin
              o_conv_en <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// ### card_supervisor_power_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module card_supervisor_power_ctrl_monitor (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // pins seen by the block
  input wire logic i_card_detect_pin,
  input wire logic i_shutdown_in_n,
  input wire logic i_oc_vcc,
  // outputs under watch
  input wire logic o_irq_out_n,
  input wire logic o_conv_en,
  input wire logic o_card_vcc_en,
  input wire logic o_card_io_en,
  input wire logic o_card_clk_en,
  input wire logic o_card_rst,
  input wire logic o_power_down_mode,
  input wire logic o_sleep_mode,
  input wire logic o_bias_reduced
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // no contact or converter enable at all
  sequence s_quiet;
    !o_conv_en && !o_card_vcc_en && !o_card_io_en && !o_card_clk_en && !o_card_rst;
  endsequence
  // deactivation steps: reset drops before the clock, io outlives the clock
  sequence s_clk_stop;
    $fell(o_card_clk_en) ##0 o_card_io_en;
  endsequence
  sequence s_vcc_down;
    $fell(o_card_vcc_en) ##0 o_conv_en;
  endsequence
  chk_reset_quiet: assert property ($fell(i_rst) |-> s_quiet)
    else $error("contacts active after reset");
  chk_por_irq_low: assert property ($fell(i_rst) |-> !o_irq_out_n [*2])
    else $error("interrupt high after power-on reset");
  chk_conv_first: assert property ($rose(o_conv_en) |-> !o_card_vcc_en && !o_card_clk_en)
    else $error("converter not first");
  chk_vcc_order: assert property ($rose(o_card_vcc_en) |-> o_conv_en && !o_card_io_en)
    else $error("supply ramp out of order");
  chk_clk_order: assert property ($rose(o_card_clk_en) |-> o_card_io_en && o_card_vcc_en)
    else $error("clock enabled before io");
  chk_clk_after_rst: assert property (s_clk_stop |-> !o_card_rst)
    else $error("clock stopped before reset");
  chk_vcc_after_io: assert property (s_vcc_down |-> !o_card_io_en && !o_card_clk_en)
    else $error("supply dropped before io");
  chk_presence_irq: assert property ($changed(i_card_detect_pin) |-> ##[1:6] !o_irq_out_n)
    else $error("no interrupt on presence change");
  chk_shutdown_flag_irq: assert property ($fell(i_shutdown_in_n) |-> ##[1:6] !o_irq_out_n)
    else $error("no interrupt on shut-down");
  chk_oc_deact: assert property (i_oc_vcc && o_card_clk_en |-> ##[1:800] !o_card_clk_en)
    else $error("overcurrent did not deactivate");
  chk_pd_card_off: assert property (o_power_down_mode |-> !o_card_vcc_en && o_bias_reduced)
    else $error("power-down with card powered");
  chk_sleep_powered: assert property (o_sleep_mode |-> o_card_vcc_en && o_bias_reduced)
    else $error("sleep without card power");
endmodule
bind card_supervisor_power_ctrl card_supervisor_power_ctrl_monitor card_supervisor_power_ctrl_monitor_inst (
  .i_core_clk, .i_rst, .i_card_detect_pin, .i_shutdown_in_n, .i_oc_vcc, .o_irq_out_n, .o_conv_en,
  .o_card_vcc_en, .o_card_io_en, .o_card_clk_en, .o_card_rst, .o_power_down_mode, .o_sleep_mode,
  .o_bias_reduced
);
`default_nettype wire

// ### smart_card_model.sv
`timescale 1ns/10ps
`default_nettype none
module smart_card_model (
  // contact supply from the reader
  input wire logic i_vcc_en,
  // bench commands
  input wire logic i_inserted,
  input wire logic i_short,
  // detector levels seen by the reader
  output logic o_present,
  output logic o_oc_vcc
);
  // detect switch closes only while the card is seated
  assign o_present = i_inserted;
  // a shorted card draws excess current only once powered
  assign o_oc_vcc = i_short && i_vcc_en;
endmodule
`default_nettype wire

// ### card_supervisor_power_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "card_supervisor_defs.vh"
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", nm, ex, gt); end end
`define WAIT(c, lim) begin k = 0; while ((c) !== 1'b1 && k < lim) begin @(negedge i_core_clk); \
  k++; end if ((c) !== 1'b1) begin error_cnt++; summarize(); end end
module card_supervisor_power_ctrl_tb;
  // stimulus
  logic i_core_clk, i_rst, i_reg_wr, i_reg_rd, i_power_down_bit, i_ext_irq_enable;
  logic i_supply_alarm, i_shutdown_in_n, i_ext_reset_pin, i_oc_rst, i_overtemp, i_rx;
  logic i_ext_irq_in_n, i_converter_supply_pin_high, ins, shrt;
  logic [3:0] i_reg_addr;
  logic [7:0] i_reg_wdata, v;
  // observed
  wire [7:0] o_reg_rdata;
  wire [1:0] o_conv_mode;
  wire o_irq_out_n, o_wake_resume, o_conv_en, o_card_vcc_en, o_card_io_en, o_card_clk_en;
  wire o_card_rst, o_power_down_mode, o_sleep_mode, i_card_detect_pin, i_oc_vcc;
  wire o_ctrl_reset, o_conv_clk, o_clk_stop, o_clk_stop_high;
  int error_cnt = 0;
  int n_checks = 0;
  int k;
  // converter mode table: control value, input level, expected mode
  logic [7:0] pt [5] = '{8'h01, 8'h03, 8'h03, 8'h01, 8'h09};
  logic dt [5] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
  logic [1:0] mt [5] = '{`CM_TRIPLE, `CM_DOUBLE, `CM_FOLLOW, `CM_DOUBLE, `CM_FOLLOW};

  card_supervisor_power_ctrl card_supervisor_power_ctrl_inst (
    .i_core_clk, .i_rst, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata,
    .i_power_down_bit, .i_ext_irq_enable, .o_irq_out_n, .o_ctrl_reset, .o_wake_resume,
    .i_card_detect_pin, .i_supply_alarm, .i_shutdown_in_n, .i_ext_reset_pin, .i_oc_vcc,
    .i_oc_rst, .i_overtemp, .i_rx, .i_ext_irq_in_n, .i_converter_supply_pin_high, .o_conv_en, .o_conv_clk,
    .o_conv_mode, .o_card_vcc_en, .o_card_io_en, .o_card_clk_en, .o_card_rst, .o_clk_stop,
    .o_clk_stop_high, .o_power_down_mode, .o_sleep_mode, .o_bias_reduced()
  );
  smart_card_model smart_card_model_inst (
    .i_vcc_en(o_card_vcc_en), .i_inserted(ins), .i_short(shrt),
    .o_present(i_card_detect_pin), .o_oc_vcc(i_oc_vcc)
  );

  // register access, one strobe cycle each
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'h1;
    @(negedge i_core_clk);
    i_reg_wr = 1'h0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(negedge i_core_clk);
    i_reg_addr = a;
    i_reg_rd = 1'h1;
    @(negedge i_core_clk);
    i_reg_rd = 1'h0;
    v = o_reg_rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  task automatic summarize();
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic t_por();
    cyc(2);
    `CHK("irq", 1'h0, o_irq_out_n)
    rd(`A_HSTAT);
    `CHK("hsr", 8'h10, v)
    cyc(1);
    `CHK("irq", 1'h1, o_irq_out_n)
    rd(`A_HSTAT);
    `CHK("hsr", 8'h00, v)
    rd(4'h4);
    `CHK("unmapped", 8'h00, v)
  endtask
  // run bit low zeroes timeout config and clears two ucfga bits; guard time kept
  task automatic t_run();
    wr(`A_RUN, 8'h08);
    wr(`A_TOC, 8'h5a);
    wr(`A_UCFGA, 8'h7f);
    wr(`A_GUARD, 8'ha5);
    rd(`A_TOC);
    `CHK("toc", 8'h5a, v)
    wr(`A_RUN, 8'h00);
    cyc(1);
    rd(`A_TOC);
    `CHK("toc", 8'h00, v)
    rd(`A_UCFGA);
    `CHK("ucfga", 8'h73, v)
    rd(`A_GUARD);
    `CHK("guard", 8'ha5, v)
    wr(`A_CLKCFG, 8'h20);
    cyc(2);
    `CHK("stop_hi", 1'h1, o_clk_stop_high)
    `CHK("stop", 1'h0, o_clk_stop)
  endtask
  task automatic t_refuse_insert();
    wr(`A_PWR, 8'h01);
    cyc(3);
    `CHK("conv", 1'h0, o_conv_en)
    rd(`A_PWR);
    `CHK("pcr", 8'h00, v)
    ins = 1'h1;
    cyc(6);
    rd(`A_FIFO_MIX);
    `CHK("msr", 8'h44, v)
    rd(`A_HSTAT);
    `CHK("hsr", 8'h04, v)
  endtask
  task automatic t_modes();
    for (int i = 0; i < 5; i++) begin
      i_converter_supply_pin_high = dt[i];
      cyc(3);
      wr(`A_PWR, pt[i]);
      `WAIT(o_conv_en, 5)
      `CHK("mode", mt[i], o_conv_mode)
      `CHK("vcc", 1'h0, o_card_vcc_en)
      wr(`A_PWR, 8'h00);
      `WAIT(!o_conv_en, 6000)
    end
  endtask
  // overheating in a session, reset-contact overcurrent, then a supply alarm
  task automatic t_heat();
    wr(`A_PWR, 8'h01);
    `WAIT(o_card_clk_en, 5100)
    v[0] = o_conv_clk;
    cyc(10);
    `CHK("pump", ~v[0], o_conv_clk)
    i_overtemp = 1'h1;
    `WAIT(!o_card_clk_en, 800)
    i_overtemp = 1'h0;
    rd(`A_PWR);
    `CHK("pcr", 8'h00, v)
    rd(`A_HSTAT);
    `CHK("ot", 1'h1, v[`B_OT])
    i_oc_rst = 1'h1;
    cyc(4);
    i_oc_rst = 1'h0;
    cyc(4);
    rd(`A_HSTAT);
    `CHK("ocr", 1'h1, v[`B_OC])
    `WAIT(!o_conv_en, 5000)
    `CHK("pump", 1'h0, o_conv_clk)
    i_supply_alarm = 1'h1;
    cyc(4);
    `CHK("irq", 1'h0, o_irq_out_n)
    `CHK("creset", 1'h1, o_ctrl_reset)
    i_supply_alarm = 1'h0;
    cyc(4);
    rd(`A_HSTAT);
    `CHK("supply_low_flag", 1'h1, v[`B_SUPPLY_LOW_FLAG])
  endtask
  // full session, sleep, then a short on the card supply
  task automatic t_fault();
    i_converter_supply_pin_high = 1'h0;
    wr(`A_PWR, 8'h05);
    `WAIT(o_conv_en, 5)
    `WAIT(o_card_vcc_en, 2000)
    `CHK("vcc_t", 1'h1, (k > 1870 && k < 1880))
    `WAIT(o_card_clk_en, 3200)
    `WAIT(o_card_rst, 3)
    i_power_down_bit = 1'h1;
    cyc(3);
    `CHK("sleep", 1'h1, o_sleep_mode)
    `CHK("cstop", 1'h1, o_clk_stop)
    i_power_down_bit = 1'h0;
    shrt = 1'h1;
    `WAIT(!o_card_clk_en, 800)
    rd(`A_PWR);
    `CHK("pcr", 8'h04, v)
    `CHK("irq", 1'h0, o_irq_out_n)
    `WAIT(!o_conv_en, 5000)
    shrt = 1'h0;
    rd(`A_HSTAT);
    `CHK("oc", 1'h1, v[`B_OC])
  endtask
  // firmware sets both enables for receive and external interrupt wake
  task automatic t_wake();
    i_power_down_bit = 1'h1;
    i_ext_irq_enable = 1'h1;
    wr(`A_UCFGB, 8'h90);
    cyc(3);
    `CHK("pdm", 1'h1, o_power_down_mode)
    for (int i = 0; i < 3; i++) begin
      if (i == 0) ins = 1'h0;
      else if (i == 1) i_rx = 1'h0;
      else i_ext_irq_in_n = 1'h0;
      `WAIT(o_wake_resume, 1600)
      `CHK("wake_t", 1'h1, (k > 1528 && k < 1545))
      i_rx = 1'h1;
      i_ext_irq_in_n = 1'h1;
      cyc(4);
    end
    wr(`A_UCFGB, 8'h00);
    i_rx = 1'h0;
    v = 8'h00;
    repeat (1600) begin
      @(negedge i_core_clk);
      v = v | {7'h0, o_wake_resume};
    end
    `CHK("no_wake", 8'h00, v)
    i_rx = 1'h1;
    i_power_down_bit = 1'h0;
  endtask
  task automatic t_shutdown();
    rd(`A_HSTAT);
    cyc(1);
    `CHK("irq", 1'h1, o_irq_out_n)
    i_shutdown_in_n = 1'h0;
    cyc(6);
    `CHK("irq", 1'h0, o_irq_out_n)
    rd(`A_HSTAT);
    `CHK("shutdown_flag", 1'h1, v[`B_SHUTDOWN_FLAG])
    // firmware answer: card already off, so straight to power-down
    i_power_down_bit = 1'h1;
    cyc(3);
    `CHK("pdm", 1'h1, o_power_down_mode)
    i_power_down_bit = 1'h0;
    i_shutdown_in_n = 1'h1;
    cyc(6);
    rd(`A_HSTAT);
    `CHK("supply_low_flag", 1'h1, v[`B_SUPPLY_LOW_FLAG])
    i_ext_reset_pin = 1'h1;
    cyc(4);
    i_ext_reset_pin = 1'h0;
    cyc(4);
    rd(`A_HSTAT);
    `CHK("supply_low_flag", 1'h1, v[`B_SUPPLY_LOW_FLAG])
  endtask

  // free-running core clock
  initial begin
    i_core_clk = 1'h0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  initial begin
    {i_reg_wr, i_reg_rd, i_power_down_bit, i_ext_irq_enable, i_supply_alarm} = 5'h00;
    {i_ext_reset_pin, i_oc_rst, i_overtemp, i_converter_supply_pin_high, ins, shrt} = 6'h00;
    {i_rst, i_shutdown_in_n, i_rx, i_ext_irq_in_n} = 4'hf;
    i_reg_addr = 4'h0;
    i_reg_wdata = 8'h00;
    repeat (20) @(negedge i_core_clk);
    i_rst = 1'h0;
    t_por();
    t_run();
    t_refuse_insert();
    t_modes();
    t_heat();
    t_fault();
    t_wake();
    t_shutdown();
    summarize();
  end
endmodule
`default_nettype wire
